// ### rtl/rtcc_ctrl.v
// Control register, enable and soft reset sequencing, and prescaler of the real-time counter
//
// Function
// RULE1 - Mode code selects wide, half or calendar counter
// RULE2 - Mode and prescale apply directly, no busy; a mode write sets busy, since it shares the low byte with enable
// RULE3 - Tick divides source by two to prescale code
// RULE4 - Enable bit reads back written value immediately
// RULE5 - Peripheral switches only after synchronisation delay
// RULE6 - Enable write sets busy; cleared on completion
// RULE7 - Enable and soft reset writable while running
// RULE8 - Writing zero to soft reset does nothing
// RULE9 - Soft reset restores registers except debug control
// RULE10 - Soft reset write discards all other fields
// RULE11 - Soft reset completes late, clears bit, busy
// RULE12 - Soft reset bit reads one while pending
// RULE13 - Clear on match only in wide, calendar
// RULE14 - Clear on match writable only while disabled
// RULE15 - Clear on match set clears counter on match
// RULE16 - Control register at zero, resets to zero
// RULE17 - Hour format bit, calendar only, disabled writes
// RULE18 - Protected writes while enabled are ignored
// RULE19 - Software waits for busy clear before retrying
`timescale 1ns/10ps
`include "rtcc_map.vh"

module rtcc_ctrl #(
	parameter SYNC_EDGES = 3,
	parameter SYNC_W     = 3,
	parameter PRESC_W    = 10
) (
	// Clock and reset
	input  wire        core_clk,
	input  wire        rst,
	// Register port
	input  wire        reg_wr_en,
	input  wire        reg_rd_en,
	input  wire [5:0]  reg_addr,
	input  wire [1:0]  reg_byte_en,
	input  wire [15:0] reg_wdata,
	output reg  [15:0] reg_rdata_ff,
	// Counter source clock pin
	input  wire        rtc_source_clock,
	// Match from the counter
	input  wire        cmp0_match,
	// Controls to the counter
	output wire        peripheral_on,
	output wire [1:0]  op_mode,
	output wire [3:0]  prescale_code,
	output wire        clear_on_match,
	output wire        hour_format_select,
	output reg         counter_tick_clock,
	output reg         counter_clear,
	output reg         soft_reset_done,
	output wire        debug_run_control,
	output wire        sync_busy_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer states

	localparam [1:0] ST_IDLE     = 2'b00;
	localparam [1:0] ST_EN_SYNC  = 2'b01;
	localparam [1:0] ST_RST_SYNC = 2'b10;

	localparam [SYNC_W-1:0] SYNC_LOAD = SYNC_EDGES[SYNC_W-1:0];
	localparam [SYNC_W-1:0] SYNC_LAST = {{(SYNC_W-1){1'b0}}, 1'b1};
	localparam [SYNC_W-1:0] SYNC_ONE  = {{(SYNC_W-1){1'b0}}, 1'b1};
	localparam [PRESC_W-1:0] PCNT_ONE  = {{(PRESC_W-1){1'b0}}, 1'b1};
	localparam [PRESC_W-1:0] PCNT_ZERO = {PRESC_W{1'b0}};

	////////////////////////////////////////////////////////////////////////////////
	// Functions

	// Low-bit mask of the prescale counter for a division by two to the code
	function [PRESC_W-1:0] presc_mask;
		input [3:0] code;
		reg   [PRESC_W:0] one_hot;
		begin
			one_hot    = {{PRESC_W{1'b0}}, 1'b1} << code;
			presc_mask = one_hot[PRESC_W-1:0] - PCNT_ONE;
		end
	endfunction

	// Modes in which clear on match is meaningful
	function mode_has_mclr;
		input [1:0] mode;
		begin
			mode_has_mclr = (mode == `RTCC_MODE_WIDE) || (mode == `RTCC_MODE_CAL);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Registers

	reg               enable_ff;
	reg               enabled_ff;
	reg               soft_reset_bit_ff;
	reg               busy_ff;
	reg [1:0]         mode_ff;
	reg [3:0]         presc_ff;
	reg               mclr_ff;
	reg               hourf_ff;
	reg               dbg_ff;
	reg [1:0]         state_ff;
	reg [SYNC_W-1:0]  sync_cnt_ff;
	reg [PRESC_W-1:0] pcnt_ff;

	reg               nxt_enable;
	reg               nxt_enabled;
	reg               nxt_soft_reset_bit;
	reg               nxt_busy;
	reg [1:0]         nxt_mode;
	reg [3:0]         nxt_presc;
	reg               nxt_mclr;
	reg               nxt_hourf;
	reg               nxt_dbg;
	reg [1:0]         nxt_state;
	reg [SYNC_W-1:0]  nxt_sync_cnt;
	reg               nxt_done;

	reg [15:0]        ctrl_rd;
	reg [15:0]        stat_rd;

	wire              src_level;
	wire              src_rise;

	////////////////////////////////////////////////////////////////////////////////
	// Source clock pin

	rtcc_pin_sync u_src_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.pin_in   (rtc_source_clock),
		.level_ff (src_level),
		.rise_ff  (src_rise)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Register port decode

	wire ctrl_sel   = reg_addr == `RTCC_CTRL_ADDR;
	wire stat_sel   = reg_addr == `RTCC_STAT_ADDR;
	wire ctrl_wr_lo = reg_wr_en & ctrl_sel & reg_byte_en[`RTCC_LANE_LO];
	wire ctrl_wr_hi = reg_wr_en & ctrl_sel & reg_byte_en[`RTCC_LANE_HI];
	wire dbg_wr     = reg_wr_en & stat_sel & reg_byte_en[`RTCC_LANE_HI];

	wire soft_reset_bit_req  = ctrl_wr_lo & reg_wdata[`RTCC_SOFT_RESET_BIT_BIT]; // RULE8
	wire unlocked   = ~enable_ff & ~enabled_ff;

	wire [1:0] wr_mode  = reg_wdata[`RTCC_MODE_MSB:`RTCC_MODE_LSB];
	wire [3:0] wr_presc = reg_wdata[`RTCC_PRESC_MSB:`RTCC_PRESC_LSB];

	////////////////////////////////////////////////////////////////////////////////
	// Next-state logic

	always @* begin
		nxt_enable   = enable_ff;
		nxt_enabled  = enabled_ff;
		nxt_soft_reset_bit    = soft_reset_bit_ff;
		nxt_busy     = busy_ff;
		nxt_mode     = mode_ff;
		nxt_presc    = presc_ff;
		nxt_mclr     = mclr_ff;
		nxt_hourf    = hourf_ff;
		nxt_dbg      = dbg_ff;
		nxt_state    = state_ff;
		nxt_sync_cnt = sync_cnt_ff;
		nxt_done     = 1'b0;

		// Completion of a pending operation, counted in source clock edges
		case (state_ff)
			ST_IDLE: begin
				nxt_state = ST_IDLE;
			end
			ST_EN_SYNC: begin
				if (src_rise) begin
					if (sync_cnt_ff == SYNC_LAST) begin
						nxt_enabled = enable_ff; // RULE5
						nxt_busy    = 1'b0; // RULE6
						nxt_state   = ST_IDLE;
					end else begin
						nxt_sync_cnt = sync_cnt_ff - SYNC_ONE;
					end
				end
			end
			ST_RST_SYNC: begin
				if (src_rise) begin
					if (sync_cnt_ff == SYNC_LAST) begin
						// Everything returns to reset except debug control
						nxt_enable  = 1'b0; // RULE9
						nxt_enabled = 1'b0; // RULE9
						nxt_mode    = `RTCC_MODE_RST; // RULE9
						nxt_presc   = `RTCC_PRESC_RST; // RULE9
						nxt_mclr    = 1'b0; // RULE9
						nxt_hourf   = 1'b0; // RULE9
						nxt_soft_reset_bit   = 1'b0; // RULE11
						nxt_busy    = 1'b0; // RULE11
						nxt_done    = 1'b1;
						nxt_state   = ST_IDLE;
					end else begin
						nxt_sync_cnt = sync_cnt_ff - SYNC_ONE;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase

		// Writes follow completion so a new request wins over an enable completion in the same cycle
		if (state_ff != ST_RST_SYNC) begin
			if (soft_reset_bit_req) begin
				// Other fields of this write are dropped
				nxt_soft_reset_bit    = 1'b1; // RULE10
				nxt_busy     = 1'b1; // RULE11
				nxt_state    = ST_RST_SYNC; // RULE11
				nxt_sync_cnt = SYNC_LOAD; // RULE11
			end else begin
				if (ctrl_wr_lo) begin
					nxt_enable   = reg_wdata[`RTCC_ENABLE_BIT]; // RULE4 RULE7
					nxt_busy     = 1'b1; // RULE6
					nxt_state    = ST_EN_SYNC; // RULE5
					nxt_sync_cnt = SYNC_LOAD; // RULE5
					if (unlocked) begin
						if (wr_mode != `RTCC_MODE_RSVD) begin
							nxt_mode = wr_mode; // RULE1 RULE2
						end
						nxt_mclr  = reg_wdata[`RTCC_MCLR_BIT]; // RULE14
						nxt_hourf = reg_wdata[`RTCC_HOURF_BIT]; // RULE17
					end
				end
				// Reserved prescale codes are not stored
				if (ctrl_wr_hi && unlocked && (wr_presc <= `RTCC_PRESC_MAX)) begin
					nxt_presc = wr_presc; // RULE2 RULE3 RULE18
				end
			end
		end

		// Debug control survives soft reset and is written at any time
		if (dbg_wr) begin
			nxt_dbg = reg_wdata[`RTCC_DBG_BIT]; // RULE9
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register readback

	always @* begin
		ctrl_rd = `RTCC_CTRL_RST; // RULE16
		ctrl_rd[`RTCC_SOFT_RESET_BIT_BIT]  = soft_reset_bit_ff; // RULE12
		ctrl_rd[`RTCC_ENABLE_BIT] = enable_ff; // RULE4
		ctrl_rd[`RTCC_MODE_MSB:`RTCC_MODE_LSB]   = mode_ff;
		ctrl_rd[`RTCC_PRESC_MSB:`RTCC_PRESC_LSB] = presc_ff;
		// Mode-dependent layout of the upper control bits
		ctrl_rd[`RTCC_MCLR_BIT]  = mclr_ff & mode_has_mclr(mode_ff); // RULE16
		ctrl_rd[`RTCC_HOURF_BIT] = hourf_ff & (mode_ff == `RTCC_MODE_CAL); // RULE16

		stat_rd = `RTCC_CTRL_RST;
		stat_rd[`RTCC_BUSY_BIT] = busy_ff; // RULE6
		stat_rd[`RTCC_DBG_BIT]  = dbg_ff;
	end

	////////////////////////////////////////////////////////////////////////////////
	// State registers

	always @(posedge core_clk) begin
		if (rst) begin
			enable_ff   <= 1'b0;
			enabled_ff  <= 1'b0;
			soft_reset_bit_ff    <= 1'b0;
			busy_ff     <= 1'b0;
			mode_ff     <= `RTCC_MODE_RST;
			presc_ff    <= `RTCC_PRESC_RST;
			mclr_ff     <= 1'b0;
			hourf_ff    <= 1'b0;
			dbg_ff      <= 1'b0;
			state_ff    <= ST_IDLE;
			sync_cnt_ff <= {SYNC_W{1'b0}};
		end else begin
			enable_ff   <= nxt_enable;
			enabled_ff  <= nxt_enabled;
			soft_reset_bit_ff    <= nxt_soft_reset_bit;
			busy_ff     <= nxt_busy;
			mode_ff     <= nxt_mode;
			presc_ff    <= nxt_presc;
			mclr_ff     <= nxt_mclr;
			hourf_ff    <= nxt_hourf;
			dbg_ff      <= nxt_dbg;
			state_ff    <= nxt_state;
			sync_cnt_ff <= nxt_sync_cnt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read data, one cycle after the read strobe

	always @(posedge core_clk) begin
		if (rst) begin
			reg_rdata_ff <= `RTCC_CTRL_RST;
		end else if (reg_rd_en) begin
			if (ctrl_sel) begin
				reg_rdata_ff <= ctrl_rd;
			end else if (stat_sel) begin
				reg_rdata_ff <= stat_rd;
			end else begin
				reg_rdata_ff <= `RTCC_CTRL_RST;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Prescaler: one tick per two-to-the-code source edges while running

	always @(posedge core_clk) begin
		if (rst) begin
			pcnt_ff            <= PCNT_ZERO;
			counter_tick_clock <= 1'b0;
		end else begin
			counter_tick_clock <= 1'b0;
			if (!enabled_ff) begin
				pcnt_ff <= PCNT_ZERO;
			end else if (src_rise) begin
				if ((pcnt_ff & presc_mask(presc_ff)) == presc_mask(presc_ff)) begin
					pcnt_ff            <= PCNT_ZERO;
					counter_tick_clock <= 1'b1; // RULE3
				end else begin
					pcnt_ff <= pcnt_ff + PCNT_ONE; // RULE3
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Clear on match and soft reset completion pulse

	always @(posedge core_clk) begin
		if (rst) begin
			counter_clear   <= 1'b0;
			soft_reset_done <= 1'b0;
		end else begin
			counter_clear   <= enabled_ff & clear_on_match & cmp0_match; // RULE15
			soft_reset_done <= nxt_done; // RULE9
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs to the counter

	assign peripheral_on      = enabled_ff;
	assign op_mode            = mode_ff; // RULE1
	assign prescale_code      = presc_ff;
	assign clear_on_match     = mclr_ff & mode_has_mclr(mode_ff); // RULE13
	assign hour_format_select = hourf_ff & (mode_ff == `RTCC_MODE_CAL); // RULE17
	assign debug_run_control  = dbg_ff;
	assign sync_busy_flag     = busy_ff;

endmodule

// ### rtl/rtcc_map.vh
// Register map, field positions, codes and reset values of the counter control block
`ifndef RTCC_MAP_VH
`define RTCC_MAP_VH

// Register byte offsets
`define RTCC_CTRL_ADDR     6'h00
`define RTCC_STAT_ADDR     6'h0a

// Control register fields
`define RTCC_SOFT_RESET_BIT_BIT     0
`define RTCC_ENABLE_BIT    1
`define RTCC_MODE_LSB      2
`define RTCC_MODE_MSB      3
`define RTCC_HOURF_BIT     6
`define RTCC_MCLR_BIT      7
`define RTCC_PRESC_LSB     8
`define RTCC_PRESC_MSB     11

// Status and debug halfword: status in the low byte, debug control in the high byte
`define RTCC_BUSY_BIT      7
`define RTCC_DBG_BIT       8

// Byte lanes of the register port
`define RTCC_LANE_LO       0
`define RTCC_LANE_HI       1

// Reset values
`define RTCC_CTRL_RST      16'h0000
`define RTCC_MODE_RST      2'h0
`define RTCC_PRESC_RST     4'h0

// Operating mode codes
`define RTCC_MODE_WIDE     2'h0
`define RTCC_MODE_HALF     2'h1
`define RTCC_MODE_CAL      2'h2
`define RTCC_MODE_RSVD     2'h3

// Highest legal prescale code, divide by 1024
`define RTCC_PRESC_MAX     4'ha

`endif

// ### rtl/rtcc_pin_sync.v
// Three-stage pin synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/10ps

module rtcc_pin_sync (
	// Clock and reset
	input  wire core_clk,
	input  wire rst,
	// Asynchronous pin
	input  wire pin_in,
	// Filtered level and its rising edge
	output reg  level_ff,
	output reg  rise_ff
);

	reg s1_ff;
	reg s2_ff;
	reg s3_ff;

	always @(posedge core_clk) begin
		if (rst) begin
			s1_ff    <= 1'b0;
			s2_ff    <= 1'b0;
			s3_ff    <= 1'b0;
			level_ff <= 1'b0;
			rise_ff  <= 1'b0;
		end else begin
			s1_ff   <= pin_in;
			s2_ff   <= s1_ff;
			s3_ff   <= s2_ff;
			rise_ff <= 1'b0;
			// A change counts once the second and third stages agree
			if (s2_ff == s3_ff) begin
				level_ff <= s3_ff;
				rise_ff  <= s3_ff & ~level_ff;
			end
		end
	end

endmodule

// ### verification/rtcc_ctrl_monitor.sv
// Port checker for the counter control block
`timescale 1ns/10ps
module rtcc_ctrl_monitor (
	// Clock and reset
	input wire        core_clk,
	input wire        rst,
	// Register port
	input wire        reg_wr_en,
	input wire        reg_rd_en,
	input wire [5:0]  reg_addr,
	input wire [1:0]  reg_byte_en,
	input wire [15:0] reg_wdata,
	input wire [15:0] reg_rdata_ff,
	// Counter side
	input wire        rtc_source_clock,
	input wire        cmp0_match,
	input wire        peripheral_on,
	input wire [1:0]  op_mode,
	input wire [3:0]  prescale_code,
	input wire        clear_on_match,
	input wire        hour_format_select,
	input wire        counter_tick_clock,
	input wire        counter_clear,
	input wire        soft_reset_done,
	input wire        debug_run_control,
	input wire        sync_busy_flag
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	property p_rst_val; $fell(rst) |-> !sync_busy_flag && !peripheral_on && op_mode == 2'h0; endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset values wrong");
	property p_mode; op_mode != 2'h3; endproperty
	a_mode: assert property (p_mode) else $error("reserved mode applied");
	property p_presc; prescale_code <= 4'ha; endproperty
	a_presc: assert property (p_presc) else $error("reserved prescale applied");
	property p_half; op_mode == 2'h1 |-> !clear_on_match; endproperty
	a_half: assert property (p_half) else $error("clear on match in half mode");
	property p_hour; op_mode != 2'h2 |-> !hour_format_select; endproperty
	a_hour: assert property (p_hour) else $error("hour format outside calendar");
	property p_busy; reg_wr_en && reg_addr == 6'h00 && reg_byte_en[0] |=> sync_busy_flag; endproperty
	a_busy: assert property (p_busy) else $error("busy not set by write");
	property p_direct; reg_wr_en && reg_byte_en == 2'h2 && !sync_busy_flag |=> !sync_busy_flag;
	endproperty
	a_direct: assert property (p_direct) else $error("prescale write set busy");
	property p_late; !$stable(peripheral_on) |-> $past(sync_busy_flag); endproperty
	a_late: assert property (p_late) else $error("enable switched without sync");
	property p_prot; peripheral_on && !sync_busy_flag |=> $stable(op_mode) && $stable(prescale_code);
	endproperty
	a_prot: assert property (p_prot) else $error("protected field changed");
	property p_clr; peripheral_on && clear_on_match && cmp0_match |=> counter_clear; endproperty
	a_clr: assert property (p_clr) else $error("counter clear missing");
	property p_done; soft_reset_done |-> !sync_busy_flag && !peripheral_on && op_mode == 2'h0
		&& $past(sync_busy_flag, 2); endproperty
	a_done: assert property (p_done) else $error("soft reset end state wrong");
	c_done: cover property (soft_reset_done);
	c_clr: cover property (counter_clear);
	c_on: cover property ($rose(peripheral_on));
endmodule
bind rtcc_ctrl rtcc_ctrl_monitor mon_u (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en),
	.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_byte_en(reg_byte_en),
	.reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff), .rtc_source_clock(rtc_source_clock),
	.cmp0_match(cmp0_match), .peripheral_on(peripheral_on), .op_mode(op_mode),
	.prescale_code(prescale_code), .clear_on_match(clear_on_match),
	.hour_format_select(hour_format_select), .counter_tick_clock(counter_tick_clock),
	.counter_clear(counter_clear), .soft_reset_done(soft_reset_done),
	.debug_run_control(debug_run_control), .sync_busy_flag(sync_busy_flag));

// ### verification/rtcc_src_model.sv
// Source clock and compare match model of the counter side
`timescale 1ns/10ps
module rtcc_src_model (
	// Clock
	input wire core_clk,
	// Controls from the bench
	input wire run,
	input wire match_req,
	// Counter side signals
	output reg rtc_source_clock,
	output reg cmp0_match = 1'b0
);
	// Free of the core clock phase; stands still when not running
	initial begin
		rtc_source_clock = 1'b0;
		#137;
		forever begin
			#400;
			rtc_source_clock = run ? ~rtc_source_clock : 1'b0;
		end
	end
	always @(posedge core_clk) begin
		cmp0_match <= match_req;
	end
endmodule

// ### verification/test_rtc_control_register_logic.sv
// Register level tests of the counter control block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
	$display("[ERR] %s exp %h got %h", nm, e, g); end end
module test_rtc_control_register_logic;
	reg         core_clk = 1'b0;
	reg         rst = 1'b1;
	reg         reg_wr_en = 1'b0;
	reg         reg_rd_en = 1'b0;
	reg  [5:0]  reg_addr = 6'h00;
	reg  [1:0]  reg_byte_en = 2'h0;
	reg  [15:0] reg_wdata = 16'h0000;
	reg         run = 1'b0;
	reg         match_req = 1'b0;
	wire [15:0] rdata;
	wire        src_clk, cmp0, on, mclr, hourf, tick, cclr, srdone, dbg, busy;
	wire [1:0]  mode;
	wire [3:0]  presc;
	reg  [15:0] d;
	integer     n_mismatch = 0, samples_checked = 0, i, n, em, ep, n_srdone = 0;
	initial forever #50 core_clk = ~core_clk;
	// Soft reset completion pulses, counted where the pulse is settled
	always @(negedge core_clk) if (srdone === 1'b1) n_srdone = n_srdone + 1;
	rtcc_src_model src_u (.core_clk(core_clk), .run(run), .match_req(match_req),
		.rtc_source_clock(src_clk), .cmp0_match(cmp0));
	rtcc_ctrl dut_u (.core_clk(core_clk), .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_byte_en(reg_byte_en), .reg_wdata(reg_wdata),
		.reg_rdata_ff(rdata), .rtc_source_clock(src_clk), .cmp0_match(cmp0),
		.peripheral_on(on), .op_mode(mode), .prescale_code(presc), .clear_on_match(mclr),
		.hour_format_select(hourf), .counter_tick_clock(tick), .counter_clear(cclr),
		.soft_reset_done(srdone), .debug_run_control(dbg), .sync_busy_flag(busy));
	////////////////////////////////////////////////////////////////
	task end_of_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
			if (n_mismatch == 0 && samples_checked > 0) $display("Regression OK");
			else $display("Regression broken");
			$finish;
		end
	endtask
	task wr(input [5:0] a, input [1:0] be, input [15:0] v);
		begin
			@(negedge core_clk);
			reg_wr_en = 1'b1; reg_addr = a; reg_byte_en = be; reg_wdata = v;
			@(negedge core_clk);
			reg_wr_en = 1'b0;
		end
	endtask
	task rd(input [5:0] a);
		begin
			@(negedge core_clk);
			reg_rd_en = 1'b1; reg_addr = a;
			@(negedge core_clk);
			reg_rd_en = 1'b0;
			d = rdata;
		end
	endtask
	// Software waits for busy to clear before the next control write
	task wait_idle;
		begin
			d = 16'h0080;
			for (n = 0; n < 100 && d[7] !== 1'b0; n++) rd(6'h0a);
			if (d[7] !== 1'b0) begin n_mismatch++; $display("[ERR] busy wait exp 0 got 1"); end_of_test; end
		end
	endtask
	task wait_tick;
		begin
			for (n = 0; n < 3000 && tick !== 1'b1; n++) @(negedge core_clk);
			if (tick !== 1'b1) begin n_mismatch++; $display("[ERR] tick wait exp 1 got 0"); end_of_test; end
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge core_clk);
		rst = 1'b0;
		run = 1'b1;
		rd(6'h00); `CHK("ctrl reset", 16'h0000, d)
		rd(6'h0a); `CHK("status reset", 16'h0000, d)
		rd(6'h04); `CHK("unmapped", 16'h0000, d)
		$display("test reset done");
		em = 0;
		for (i = 0; i < 4; i++) begin
			wr(6'h00, 2'h1, 16'h00c0 | (i << 2));
			wait_idle;
			if (i < 3) em = i;
			`CHK("op_mode", em[1:0], mode)
			`CHK("clear_on_match", em != 1, mclr)
			`CHK("hour_format", em == 2, hourf)
			rd(6'h00); `CHK("ctrl mode", (em << 2) | ((em != 1) << 7) | ((em == 2) << 6), d)
		end
		$display("test mode done");
		ep = 0;
		for (i = 0; i < 16; i++) begin
			wr(6'h00, 2'h2, i << 8);
			if (i <= 10) ep = i;
			`CHK("prescale", ep[3:0], presc)
			`CHK("busy direct", 1'b0, busy)
		end
		wr(6'h00, 2'h2, 16'h0200);
		$display("test prescale done");
		wr(6'h00, 2'h1, 16'h00ca);
		`CHK("on early", 1'b0, on)
		`CHK("busy set", 1'b1, busy)
		rd(6'h00); `CHK("enable readback", 1'b1, d[1])
		wait_idle;
		`CHK("on late", 1'b1, on)
		wr(6'h00, 2'h1, 16'h0002);
		wr(6'h00, 2'h2, 16'h0500);
		wait_idle;
		`CHK("mode kept", 2'h2, mode)
		`CHK("mclr kept", 1'b1, mclr)
		`CHK("hourf kept", 1'b1, hourf)
		`CHK("presc kept", 4'h2, presc)
		`CHK("on kept", 1'b1, on)
		$display("test enable done");
		wait_tick;
		@(negedge core_clk);
		for (n = 1; n < 500 && tick !== 1'b1; n++) @(negedge core_clk);
		if (tick !== 1'b1) begin n_mismatch++; $display("[ERR] tick spacing exp 32 got 500"); end_of_test; end
		`CHK("tick spacing", 32, n)
		match_req = 1'b1;
		@(negedge core_clk);
		match_req = 1'b0;
		@(negedge core_clk);
		`CHK("counter clear", 1'b1, cclr)
		$display("test tick done");
		wr(6'h0a, 2'h2, 16'h0100);
		rd(6'h0a); `CHK("debug", 16'h0100, d)
		wr(6'h00, 2'h3, 16'h0489);
		rd(6'h00); `CHK("soft_reset_bit pending", 1'b1, d[0])
		`CHK("enable kept in soft_reset_bit write", 1'b1, d[1])
		wait_idle;
		`CHK("reset done pulses", 1, n_srdone)
		rd(6'h00); `CHK("ctrl after soft_reset_bit", 16'h0000, d)
		`CHK("on after soft_reset_bit", 1'b0, on)
		`CHK("presc after soft_reset_bit", 4'h0, presc)
		`CHK("debug kept", 1'b1, dbg)
		wr(6'h00, 2'h1, 16'h0002);
		wait_idle;
		`CHK("on again", 1'b1, on)
		match_req = 1'b1;
		@(negedge core_clk);
		match_req = 1'b0;
		@(negedge core_clk);
		`CHK("no clear", 1'b0, cclr)
		$display("test soft reset done");
		end_of_test;
	end
endmodule
